// >>> shared/wdcts_cfg.svh
`ifndef WDCTS_CFG_SVH
`define WDCTS_CFG_SVH

// ==========================================================
// Timing
`define WDCTS_CLK_PERIOD_NS      10
`define WDCTS_TICK_PERIOD_NS     1000000
`define WDCTS_TICK_CYCLES        (`WDCTS_TICK_PERIOD_NS / `WDCTS_CLK_PERIOD_NS)
`define WDCTS_TICK_CNT_W         17

// ==========================================================
// Overflow exponents
`define WDCTS_INT_SHORT_EXP      5
`define WDCTS_INT_LONG_EXP       8
`define WDCTS_BUS_SHORT_EXP      13
`define WDCTS_BUS_LONG_EXP       18
`define WDCTS_CNT_W              19

// ==========================================================
// Reset values
`define WDCTS_CLKSEL_RESET       1'h0
`define WDCTS_TOSEL_RESET        1'h0
`define WDCTS_RESET_PULSE_CYCLES 4'h8

`endif

// >>> shared/wdcts_pkg.sv
package wdcts_pkg;

  typedef enum logic [2:0] {
    WDCTS_IDLE  = 3'b001,
    WDCTS_COUNT = 3'b010,
    WDCTS_FIRE  = 3'b100
  } wdcts_state_t;

  typedef logic [18:0] wdcts_count_t;

endpackage : wdcts_pkg

// >>> shared/wdcts_tick_if.sv
`timescale 1ns/1ns
interface wdcts_tick_if;
  logic tick;

  modport source (output tick);
  modport sink   (input  tick);
endinterface : wdcts_tick_if

// >>> rtl/wdcts_tick_gen.sv
`timescale 1ns/1ns
`include "wdcts_cfg.svh"
module wdcts_tick_gen (
  input  wire logic     clk_sys,
  input  wire logic     reset,
  wdcts_tick_if.source  tickBus
);

  logic [`WDCTS_TICK_CNT_W-1:0] divCount;
  wire                          divWrap = (divCount == `WDCTS_TICK_CNT_W'(`WDCTS_TICK_CYCLES - 1));

  // ==========================================================
  // Free-running 1 kHz tick, never stopped by the watchdog itself
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      divCount     <= '0;
      tickBus.tick <= 1'b0;
    end else begin
      divCount     <= divWrap ? '0 : divCount + 1'b1;
      tickBus.tick <= divWrap;
    end
  end

endmodule : wdcts_tick_gen

// >>> rtl/watchdog_clock_timeout_select.sv
`timescale 1ns/1ns
`include "wdcts_cfg.svh"
module watchdog_clock_timeout_select (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic watchdogEnable,
  input  wire logic clockSelectWrite,
  input  wire logic clockSelectData,
  input  wire logic timeoutSelectWrite,
  input  wire logic timeoutSelectData,
  input  wire logic serviceStrobe,
  output logic      watchdogClockSelect,
  output logic      watchdogTimeoutSelect,
  output logic      clockSelectLocked,
  output logic      systemReset
);

  // ==========================================================
  // Free-running internal tick source
  wdcts_tick_if tickBus ();

  wdcts_tick_gen u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tickBus (tickBus)
  );

  // ==========================================================
  // State and counters
  wdcts_pkg::wdcts_state_t state;
  wdcts_pkg::wdcts_state_t next_state;
  wdcts_pkg::wdcts_count_t count;
  logic [3:0]              pulseCount;

  // ==========================================================
  // Limit selection
  function automatic wdcts_pkg::wdcts_count_t limitOf(input logic busSel, input logic longSel);
    wdcts_pkg::wdcts_count_t lim;
    lim = '0;
    if (busSel)
      lim[longSel ? `WDCTS_BUS_LONG_EXP : `WDCTS_BUS_SHORT_EXP] = 1'b1;
    else
      lim[longSel ? `WDCTS_INT_LONG_EXP : `WDCTS_INT_SHORT_EXP] = 1'b1;
    return lim;
  endfunction : limitOf

  // ==========================================================
  // State decode
  wire inCount = (state == wdcts_pkg::WDCTS_COUNT);
  wire inFire  = (state == wdcts_pkg::WDCTS_FIRE);

  // ==========================================================
  // Count step and overflow detect
  wire                          countStep = watchdogClockSelect ? 1'b1 : tickBus.tick;
  wire wdcts_pkg::wdcts_count_t limit     = limitOf(watchdogClockSelect, watchdogTimeoutSelect);
  wire wdcts_pkg::wdcts_count_t lastCount = limit - 1'b1;
  // Greater-or-equal, so a shorter timeout written mid-count fires on the next count step instead of wrapping
  wire                          reached   = inCount && countStep && (count >= lastCount);
  wire                          pulseDone = (pulseCount == `WDCTS_RESET_PULSE_CYCLES - 1'b1);

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      wdcts_pkg::WDCTS_IDLE: begin
        if (watchdogEnable)
          next_state = wdcts_pkg::WDCTS_COUNT;
      end
      wdcts_pkg::WDCTS_COUNT: begin
        if (!watchdogEnable)
          next_state = wdcts_pkg::WDCTS_IDLE;
        else if (reached && !serviceStrobe)
          next_state = wdcts_pkg::WDCTS_FIRE;
      end
      wdcts_pkg::WDCTS_FIRE: begin
        if (pulseDone)
          next_state = wdcts_pkg::WDCTS_IDLE;
      end
      default: begin
        next_state = wdcts_pkg::WDCTS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Control bit next values; select is write-once until the next reset
  wire selectTaken                = clockSelectWrite && !clockSelectLocked;
  wire next_watchdogClockSelect   = selectTaken ? clockSelectData : watchdogClockSelect;
  wire next_clockSelectLocked     = clockSelectLocked || selectTaken;
  // Timeout stays writable at any time; the overflow compare copes with a shorter limit mid-count
  wire next_watchdogTimeoutSelect = timeoutSelectWrite ? timeoutSelectData : watchdogTimeoutSelect;

  // ==========================================================
  // Clock-select bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      watchdogClockSelect <= `WDCTS_CLKSEL_RESET;
    end else begin
      watchdogClockSelect <= next_watchdogClockSelect;
    end
  end

  // ==========================================================
  // Lock flag; only a reset clears it, which restores writability
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clockSelectLocked <= 1'b0;
    end else begin
      clockSelectLocked <= next_clockSelectLocked;
    end
  end

  // ==========================================================
  // Timeout bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      watchdogTimeoutSelect <= `WDCTS_TOSEL_RESET;
    end else begin
      watchdogTimeoutSelect <= next_watchdogTimeoutSelect;
    end
  end

  // ==========================================================
  // Counter and pulse next values; service wins over a same-cycle overflow
  wire                          countClear       = !inCount || serviceStrobe || reached;
  wire wdcts_pkg::wdcts_count_t countPlusOne     = count + 1'b1;
  wire wdcts_pkg::wdcts_count_t next_count       = countClear ? '0 : (countStep ? countPlusOne : count);
  wire [3:0]                    next_pulseCount  = inFire ? pulseCount + 4'h1 : 4'h0;
  wire                          next_systemReset = (next_state == wdcts_pkg::WDCTS_FIRE);

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= wdcts_pkg::WDCTS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Watchdog counter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ==========================================================
  // Reset pulse length counter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pulseCount <= 4'h0;
    end else begin
      pulseCount <= next_pulseCount;
    end
  end

  // ==========================================================
  // System reset output, registered so it cannot glitch
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      systemReset <= 1'b0;
    end else begin
      systemReset <= next_systemReset;
    end
  end

endmodule : watchdog_clock_timeout_select

// >>> verification/wdcts_props.sv
`timescale 1ns/1ns
module wdcts_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic watchdogEnable,
  input wire logic clockSelectWrite,
  input wire logic clockSelectData,
  input wire logic timeoutSelectWrite,
  input wire logic timeoutSelectData,
  input wire logic serviceStrobe,
  input wire logic watchdogClockSelect,
  input wire logic watchdogTimeoutSelect,
  input wire logic clockSelectLocked,
  input wire logic systemReset
);
  // ==========
  // Cycles since restart; config writes restart it so the bounds stay exact
  int idle;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) idle <= 0;
    else idle <= (serviceStrobe | systemReset | !watchdogEnable | clockSelectWrite | timeoutSelectWrite) ? 0 : idle + 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence fire_s; $rose(systemReset); endsequence
  a_first_write_taken: assert property
    (clockSelectWrite && !clockSelectLocked |=> clockSelectLocked && watchdogClockSelect == $past(clockSelectData))
    else $error("select write lost");
  a_locked_select_hold: assert property
    (clockSelectLocked |=> clockSelectLocked && $stable(watchdogClockSelect)) else $error("locked select moved");
  a_timeout_write: assert property
    (timeoutSelectWrite |=> watchdogTimeoutSelect == $past(timeoutSelectData)) else $error("timeout write lost");
  a_pulse_eight: assert property
    (fire_s |-> systemReset [*8] ##1 !systemReset) else $error("reset pulse width");
  a_service_wins: assert property
    (serviceStrobe |=> !$rose(systemReset)) else $error("reset despite service");
  a_bus_short_span: assert property
    (fire_s and watchdogClockSelect |-> idle >= 8190 && (watchdogTimeoutSelect ? idle >= 262140 : 1'b1))
    else $error("bus overflow early");
  a_bus_short_late: assert property
    (watchdogClockSelect && !watchdogTimeoutSelect |-> idle < 8210) else $error("bus overflow late");
  a_tick_span: assert property
    (fire_s and !watchdogClockSelect |-> idle >= 3100000) else $error("tick overflow early");
endmodule : wdcts_props
bind watchdog_clock_timeout_select wdcts_props wdcts_props_i (.*);

// >>> verification/test_watchdog_clock_timeout_select.sv
`timescale 1ns/1ns
module test_watchdog_clock_timeout_select;
  logic clk_sys = 0, reset = 1, watchdogEnable = 0, clockSelectWrite = 0, clockSelectData = 0;
  logic timeoutSelectWrite = 0, timeoutSelectData = 0, serviceStrobe = 0;
  logic watchdogClockSelect, watchdogTimeoutSelect, clockSelectLocked, systemReset;
  int   miscompares = 0, n_compared = 0, fires = 0, f;
  watchdog_clock_timeout_select watchdog_clock_timeout_select_i (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge systemReset) fires++;
  task automatic step(int n = 1); repeat (n) @(posedge clk_sys); #1; endtask : step
  task automatic chk(logic ok, string m);
    n_compared++;
    if (ok !== 1'b1) begin miscompares++; $display("Error %0t %s", $time, m); end
  endtask : chk
  task automatic select_once;
    clockSelectWrite = 1; clockSelectData = 1; step();
    clockSelectData = 0; step();
    clockSelectWrite = 0; step();
    chk(watchdogClockSelect === 1'b1 && clockSelectLocked === 1'b1, "select lock");
  endtask : select_once
  task automatic bus_short;
    int n = 0;
    watchdogEnable = 1;
    while (systemReset !== 1'b1 && n < 9000) begin step(); n++; end
    chk(n == 8192 + 1, "overflow count");
    step(7); chk(systemReset === 1'b1, "pulse short");
    step(); chk(systemReset === 1'b0, "pulse width");
    watchdogEnable = 0; step();
  endtask : bus_short
  // Service well inside the window three times, then once in the overflow cycle itself
  task automatic serviced;
    f = fires; watchdogEnable = 1;
    repeat (3) begin step(6000); serviceStrobe = 1; step(); serviceStrobe = 0; end
    chk(fires == f, "serviced fired");
    step(8191); serviceStrobe = 1; step(); serviceStrobe = 0; step(20);
    chk(fires == f, "service lost to overflow");
    watchdogEnable = 0; step();
  endtask : serviced
  task automatic long_timeout;
    timeoutSelectWrite = 1; timeoutSelectData = 1; step(); timeoutSelectWrite = 0;
    f = fires; watchdogEnable = 1; step(9000);
    chk(fires == f && watchdogTimeoutSelect === 1'b1, "long fired");
    watchdogEnable = 0; step();
  endtask : long_timeout
  task automatic internal_after_reset;
    reset = 1; step(); reset = 0;
    chk(clockSelectLocked === 1'b0 && watchdogClockSelect === 1'b0, "reset unlock");
    chk(watchdogTimeoutSelect === 1'b0, "timeout reset");
    f = fires; watchdogEnable = 1; step(9000);
    chk(fires == f, "tick mode fired");
    watchdogEnable = 0; clockSelectWrite = 1; clockSelectData = 1; step();
    clockSelectWrite = 0; step();
    chk(watchdogClockSelect === 1'b1 && clockSelectLocked === 1'b1, "rewrite after reset");
  endtask : internal_after_reset
  task automatic tally_and_finish;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    step(8); reset = 0;
    select_once();
    bus_short();
    serviced();
    long_timeout();
    internal_after_reset();
    tally_and_finish();
  end
  initial begin #1000000; miscompares++; tally_and_finish(); end
endmodule : test_watchdog_clock_timeout_select
